// ---- common/csm_pkg.sv ----
// Package of constants and carrier types for the control source mode selector.
package csm_pkg;

	// ------------------------------------------------------------------
	// Register map (byte addresses, one aligned 32-bit word each)
	// ------------------------------------------------------------------
	localparam int unsigned ADDR_W = 6;                           // Byte address width.
	localparam logic [5:0] OFS_CTRL   = 6'h00;                    // Emergency start enable.
	localparam logic [5:0] OFS_REMOTE = 6'h04;                    // Remote mode settings.
	localparam logic [5:0] OFS_LOCAL1 = 6'h08;                    // First local mode settings.
	localparam logic [5:0] OFS_LOCAL2 = 6'h0C;                    // Second local mode settings.
	localparam logic [5:0] OFS_MFCFG  = 6'h10;                    // Multifunction functions.
	localparam logic [5:0] OFS_STATUS = 6'h14;                    // Live state, read only.

	// ------------------------------------------------------------------
	// Field positions of a per-mode settings word
	// ------------------------------------------------------------------
	localparam int unsigned MODE_W       = 11;                    // Width of a settings word.
	localparam int unsigned F_START_CYC  = 0;                     // Start permit, cyclic bus.
	localparam int unsigned F_STOP_CYC   = 1;                     // Stop permit, cyclic bus.
	localparam int unsigned F_START_ACYC = 2;                     // Start permit, acyclic bus.
	localparam int unsigned F_STOP_ACYC  = 3;                     // Stop permit, acyclic bus.
	localparam int unsigned F_START_PAN  = 4;                     // Start permit, panel.
	localparam int unsigned F_STOP_PAN   = 5;                     // Stop permit, panel.
	localparam int unsigned F_START_DI   = 6;                     // Start permit, digital inputs.
	localparam int unsigned F_STOP_DI    = 7;                     // Stop permit, digital inputs.
	localparam int unsigned F_HOLD       = 8;                     // Hold-to-run select.
	localparam int unsigned F_START_FLIP = 9;                     // Start input polarity flip.
	localparam int unsigned F_STOP_FLIP  = 10;                    // Stop input polarity flip.

	// Reset values of the settings words.
	localparam logic [10:0] RST_REMOTE = 11'h0AB;
	localparam logic [10:0] RST_LOCAL  = 11'h0F2;
	localparam logic        RST_EMERG  = 1'b0;
	localparam logic [8:0]  RST_MFCFG  = 9'h000;

	// Remote request bit inside byte 0 of the cyclic command telegram.
	localparam int unsigned REMOTE_BIT = 5;

	// ------------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		CSM_MODE_REMOTE = 3'b001,
		CSM_MODE_LOCAL1 = 3'b010,
		CSM_MODE_LOCAL2 = 3'b100
	} csm_mode_t;

	// Function codes of a multifunction input, three bits per input.
	typedef enum logic [2:0] {
		CSM_MF_NONE  = 3'h0,
		CSM_MF_FORCE = 3'h1,
		CSM_MF_TEST  = 3'h2,
		CSM_MF_STOP  = 3'h3,
		CSM_MF_EMERG = 3'h4,
		CSM_MF_FAULT = 3'h5
	} csm_mf_t;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [31:0]       writedata;
	} csm_avs_req_t;

	typedef struct packed {
		logic       bus_fault;
		logic [7:0] cyc_byte0;
		logic       cyc_start;
		logic       cyc_stop;
		logic       acyc_start;
		logic       acyc_stop;
		logic       pan_start;
		logic       pan_stop;
		logic       thermal_reset_command;
	} csm_cmd_t;

endpackage

// ---- dv/csm_ctrl_model.sv ----
// Model of the process controller that sends the cyclic command telegram.
`timescale 1ns/100ps
module csm_ctrl_model (
	// Clock.
	input wire logic          ref_clk,
	// Requests from the test sequence.
	input wire logic          fault_req,
	input wire logic          auto_req,
	input wire logic [2:0]    start_req,
	input wire logic [2:0]    stop_req,
	input wire logic          prep_req,
	// Telegram towards the device.
	output csm_pkg::csm_cmd_t cmd
);
	// Spare telegram bits keep counting, so only bit 5 may carry meaning.
	logic [7:0] spare_q;

	// Start from a quiet telegram.
	initial begin
		spare_q = 8'h00;
		cmd = '0;
	end

	// The telegram changes just after each rising edge, as a bus master would.
	always @(posedge ref_clk) begin
		spare_q <= spare_q + 8'h01;
		cmd.bus_fault <= fault_req;
		cmd.cyc_byte0 <= {spare_q[7:6], auto_req, spare_q[4:0]};
		cmd.cyc_start  <= start_req[0];
		cmd.acyc_start <= start_req[1];
		cmd.pan_start  <= start_req[2];
		cmd.cyc_stop   <= stop_req[0];
		cmd.acyc_stop  <= stop_req[1];
		cmd.pan_stop   <= stop_req[2];
		cmd.thermal_reset_command <= prep_req;
	end
endmodule

// ---- dv/csm_mode_select_properties.sv ----
// Concurrent checks on the ports of the control source mode selector.
`timescale 1ns/100ps
module csm_mode_select_properties (
	// Clock and reset.
	input wire logic                  ref_clk,
	input wire logic                  rst,
	// Register bus and commands.
	input wire csm_pkg::csm_avs_req_t avs_req,
	input wire logic                  avs_waitrequest,
	input wire csm_pkg::csm_cmd_t     cmd,
	// Results.
	input wire csm_pkg::csm_mode_t    mode,
	input wire logic                  motor_run,
	input wire logic                  start_accepted,
	input wire logic                  thermal_reset,
	input wire logic                  fault_ignore,
	input wire logic [2:0]            input_fault
);
	// ----------------------------------------------------------------
	// Common clocking; nothing is judged while reset is applied.
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// Mode selection
	// ----------------------------------------------------------------
	a_one_mode: assert property ($onehot(mode))
		else $error("mode is not one-hot");
	// A held bus fault must win over every other selector input.
	a_fault_local: assert property (cmd.bus_fault [*3] |=> mode == csm_pkg::CSM_MODE_LOCAL1)
		else $error("bus fault did not select first local mode");
	a_auto_leaves: assert property ((!cmd.bus_fault && cmd.cyc_byte0[5]) [*4]
		|=> mode != csm_pkg::CSM_MODE_LOCAL1) else $error("remote request ignored");
	// Depth 2 or 3 covers the pipeline without pinning its exact length.
	a_remote_cause: assert property (mode == csm_pkg::CSM_MODE_REMOTE
		|-> $past(cmd.cyc_byte0[5], 2) || $past(cmd.cyc_byte0[5], 3))
		else $error("remote mode without remote request");

	// ----------------------------------------------------------------
	// Starting and running
	// ----------------------------------------------------------------
	a_start_pulse: assert property (start_accepted |=> !start_accepted)
		else $error("start accept longer than one cycle");
	a_run_start: assert property ($rose(motor_run) |-> start_accepted)
		else $error("motor started without an accepted start");
	a_accept_run: assert property (start_accepted |-> motor_run)
		else $error("accepted start did not run the motor");

	// ----------------------------------------------------------------
	// Emergency start and fault masking
	// ----------------------------------------------------------------
	a_therm_pulse: assert property (thermal_reset |=> !thermal_reset)
		else $error("thermal reset longer than one cycle");
	a_therm_enable: assert property (thermal_reset |-> fault_ignore)
		else $error("thermal reset without enabled emergency source");
	a_mask_fault: assert property (fault_ignore [*3] |-> input_fault == 3'b000)
		else $error("input fault shown while masked");

	// ----------------------------------------------------------------
	// Register bus answers after exactly one wait cycle.
	// ----------------------------------------------------------------
	a_bus_answer: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus request not answered");
	a_bus_gap: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait request low for more than one cycle");
endmodule

bind csm_mode_select csm_mode_select_properties u_props (.ref_clk, .rst, .avs_req,
	.avs_waitrequest, .cmd, .mode, .motor_run, .start_accepted, .thermal_reset,
	.fault_ignore, .input_fault);

// ---- dv/testbench.sv ----
// Self-checking testbench for the control source mode selector.
`timescale 1ns/100ps
module testbench;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic ref_clk, rst, avs_waitrequest, local_forward_start_input, local_stop_input;
	logic motor_run, start_accepted, simulation, thermal_reset, fault_ignore;
	logic fault_req, auto_req, prep_req;
	logic [2:0] multifunction_inputs, input_fault, start_req, stop_req;
	logic [31:0] avs_readdata, rdv;
	csm_pkg::csm_avs_req_t avs_req;
	csm_pkg::csm_cmd_t cmd;
	csm_pkg::csm_mode_t mode;
	int errors = 0, checks = 0, sa, tr;
	// Reset table: control, three mode words, function map, unmapped place.
	logic [5:0] ra [6] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h18};
	logic [31:0] rv [6] = '{32'h0000_0000, 32'h0000_00AB, 32'h0000_00F2,
		32'h0000_00F2, 32'h0000_0000, 32'h0000_0000};

	csm_mode_select dut (.ref_clk, .rst, .avs_req, .avs_readdata, .avs_waitrequest, .cmd,
		.multifunction_inputs, .local_forward_start_input, .local_stop_input, .mode,
		.motor_run, .start_accepted, .simulation, .thermal_reset, .fault_ignore, .input_fault);
	csm_ctrl_model u_ctrl (.ref_clk, .fault_req, .auto_req, .start_req, .stop_req,
		.prep_req, .cmd);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One Avalon access; called right after an edge, held until wait request is low.
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		avs_req <= {~wr, wr, a, d};
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		rdv = avs_readdata;
		avs_req <= '0;
		@(posedge ref_clk);
	endtask

	// Counts one-cycle pulses over a window, since they stand a single cycle.
	task automatic watch(input int n);
		sa = 0;
		tr = 0;
		repeat (n) begin
			@(posedge ref_clk);
			sa += int'(start_accepted === 1'b1);
			tr += int'(thermal_reset === 1'b1);
		end
	endtask

	task automatic final_report();
		if (errors == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock and watchdog
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// The tests need about 350 cycles; twenty thousand means a hang.
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		final_report();
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		{rst, fault_req, auto_req, prep_req} = 4'b1000;
		{multifunction_inputs, start_req, stop_req} = 9'h000;
		{local_forward_start_input, local_stop_input} = 2'b00;
		avs_req = '0;
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		// Reset values, the unmapped place reading zero.
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, ra[i], 32'h0000_0000);
			chk(rdv, rv[i]);
		end
		// Inputs 0..2 as force local, test position and stop.
		bus(1'b1, csm_pkg::OFS_MFCFG, 32'h0000_00D1);
		bus(1'b0, csm_pkg::OFS_MFCFG, 32'h0000_0000);
		chk(rdv, 32'h0000_00D1);
		// Every combination of fault, force and remote request.
		for (int i = 0; i < 8; i++) begin
			{fault_req, multifunction_inputs[0], auto_req} <= i[2:0];
			repeat (8) @(posedge ref_clk);
			chk(32'(mode), i[2] ? 32'h0000_0002 : i[1] ? 32'h0000_0004 :
				i[0] ? 32'h0000_0001 : 32'h0000_0002);
		end
		multifunction_inputs[1] <= 1'b1;
		repeat (8) @(posedge ref_clk);
		chk(32'(simulation), 32'h0000_0001);
		{fault_req, multifunction_inputs, auto_req} <= 5'b0_000_1;
		repeat (8) @(posedge ref_clk);
		chk(32'(simulation), 32'h0000_0000);
		// Remote mode: each start source against its reset permit.
		for (int s = 0; s < 4; s++) begin
			if (s < 3) start_req[s] <= 1'b1;
			else local_forward_start_input <= 1'b1;
			watch(10);
			chk(32'(sa), 32'(csm_pkg::RST_REMOTE[2*s]));
			{start_req, local_forward_start_input} <= 4'h0;
			repeat (8) @(posedge ref_clk);
			chk(32'(motor_run), 32'(csm_pkg::RST_REMOTE[2*s]));
			stop_req[2] <= 1'b1;
			repeat (8) @(posedge ref_clk);
			chk(32'(motor_run), 32'h0000_0000);
			stop_req <= 3'b000;
			@(posedge ref_clk);
		end
		// A stop input refuses a permitted start.
		multifunction_inputs[2] <= 1'b1;
		repeat (8) @(posedge ref_clk);
		start_req[0] <= 1'b1;
		watch(10);
		chk(32'(sa) + 32'(motor_run), 32'h0000_0000);
		{start_req[0], multifunction_inputs[2], auto_req} <= 3'b000;
		// First local mode with hold-to-run: the motor follows the pin.
		bus(1'b1, csm_pkg::OFS_LOCAL1, 32'h0000_01F2);
		local_forward_start_input <= 1'b1;
		watch(10);
		chk(32'(sa), 32'h0000_0001);
		chk(32'(motor_run), 32'h0000_0001);
		local_forward_start_input <= 1'b0;
		repeat (8) @(posedge ref_clk);
		chk(32'(motor_run), 32'h0000_0000);
		// Flipped stop input: a low pin now means stop.
		bus(1'b1, csm_pkg::OFS_LOCAL1, 32'h0000_04F2);
		local_forward_start_input <= 1'b1;
		watch(10);
		chk(32'(sa), 32'h0000_0000);
		{local_forward_start_input, local_stop_input} <= 2'b01;
		repeat (6) @(posedge ref_clk);
		local_forward_start_input <= 1'b1;
		watch(10);
		chk(32'(sa), 32'h0000_0001);
		{local_forward_start_input, local_stop_input} <= 2'b00;
		repeat (8) @(posedge ref_clk);
		chk(32'(motor_run), 32'h0000_0000);
		// Input 0 emergency start, input 1 fault input.
		bus(1'b1, csm_pkg::OFS_MFCFG, 32'h0000_002C);
		multifunction_inputs[1] <= 1'b1;
		prep_req <= 1'b1;
		watch(10);
		chk({tr[26:0], 1'b0, fault_ignore, input_fault}, 32'h0000_0002);
		prep_req <= 1'b0;
		bus(1'b1, csm_pkg::OFS_CTRL, 32'h0000_0001);
		prep_req <= 1'b1;
		watch(10);
		chk({tr[26:0], 1'b0, fault_ignore, input_fault}, 32'h0000_0028);
		prep_req <= 1'b0;
		repeat (8) @(posedge ref_clk);
		multifunction_inputs[0] <= 1'b1;
		watch(10);
		chk({tr[26:0], 1'b0, fault_ignore, input_fault}, 32'h0000_0028);
		multifunction_inputs <= 3'b000;
		repeat (8) @(posedge ref_clk);
		// Status: quiet pins, first local mode, motor off, nothing masked.
		bus(1'b0, csm_pkg::OFS_STATUS, 32'h0000_0000);
		chk(rdv, 32'h0000_0040);
		final_report();
	end
endmodule

// ---- hw/csm_mode_select.sv ----
// Control source mode selector with command gating, start modes and emergency start.
`timescale 1ns/100ps

// Contract
// - Mode chosen from fault, override, remote request.
// - Bus fault forces first local mode.
// - Override selects second local mode otherwise.
// - Remote request picks remote, else first local.
// - Exactly one mode is always active.
// - Override comes from configured multifunction input.
// - Per mode, per source start/stop permits.
// - Starts are edge triggered; release keeps running.
// - Hold-to-run stops when start input drops.
// - Per mode hold select and polarity flips.
// - Stop input blocks every start.
// - Test position input selects simulation.
// - Emergency start needs enable; resets off.
// - Emergency input rise resets thermal memory.
// - Emergency input high masks input faults.
// - Bus command rise resets thermal memory.
// - Bus command high masks input faults.
module csm_mode_select (
	// Clock and reset.
	input  wire logic                  ref_clk,
	input  wire logic                  rst,
	// Avalon-MM slave.
	input  wire csm_pkg::csm_avs_req_t avs_req,
	output logic [31:0]                avs_readdata,
	output logic                       avs_waitrequest,
	// Commands from bus, panel and fieldbus logic on this clock.
	input  wire csm_pkg::csm_cmd_t     cmd,
	// Pins, asynchronous to the clock.
	input  wire logic [2:0]            multifunction_inputs,
	input  wire logic                  local_forward_start_input,
	input  wire logic                  local_stop_input,
	// Results.
	output csm_pkg::csm_mode_t         mode,
	output logic                       motor_run,
	output logic                       start_accepted,
	output logic                       simulation,
	output logic                       thermal_reset,
	output logic                       fault_ignore,
	output logic [2:0]                 input_fault
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [4:0]                         pin_meta;   // First synchroniser stage.
		logic [4:0]                         pin_sync;   // Second synchroniser stage.
		logic [4:0]                         pin_prev;   // Synchronised pins, one cycle older.
		csm_pkg::csm_cmd_t                  cmd_r;      // Registered commands.
		csm_pkg::csm_cmd_t                  cmd_prev;   // Commands, one cycle older.
		logic                               emerg_en;   // Emergency start enable.
		logic [csm_pkg::MODE_W-1:0]         cfg_rem;    // Remote mode settings.
		logic [csm_pkg::MODE_W-1:0]         cfg_l1;     // First local mode settings.
		logic [csm_pkg::MODE_W-1:0]         cfg_l2;     // Second local mode settings.
		logic [8:0]                         mf_cfg;     // Function of each multifunction input.
		csm_pkg::csm_mode_t                 mode;       // Active mode.
		logic                               run;        // Motor runs.
		logic                               hold_run;   // Run was started in hold-to-run.
		logic                               accepted;   // One-cycle start acceptance.
		logic                               sim;        // Simulation operation.
		logic                               th_reset;   // One-cycle thermal memory reset.
		logic                               f_ign;      // Input faults are masked.
		logic [2:0]                         fault;      // Per input fault.
		logic [31:0]                        rdata;      // Bus read data.
		logic                               waitreq;    // Bus wait request.
	} csm_state_t;

	csm_state_t s_q;  // Registered state.
	csm_state_t s_d;  // Next state.

	// Keeping every flop in one struct keeps reset and registering in a single
	// place, at the cost of resetting a few fields that would not need it.

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// OR of all multifunction inputs that carry a given function.
	// Several inputs may share one function; they are merged, so only the
	// fault flags below still tell which input raised them.
	function automatic logic csm_mf_any(input logic [8:0] cfg, input logic [2:0] lvl,
		input csm_pkg::csm_mf_t code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (cfg[i*3 +: 3] == code && lvl[i]) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	// Rising edge of a level that is held in two consecutive registers.
	function automatic logic csm_rise(input logic now_v, input logic old_v);
		return now_v & ~old_v;
	endfunction

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	// Mode and run logic read registered copies of cmd and the pins only, so a mode
	// change applies two cycles after a command moved.
	always_comb begin
		logic [csm_pkg::MODE_W-1:0] cfg;
		logic [2:0]                 mf;
		logic [2:0]                 mf_old;
		logic                       di_start;
		logic                       di_start_old;
		logic                       di_stop;
		logic                       force_loc;
		logic                       stop_dom;
		logic                       emerg_lvl;
		logic                       emerg_edge;
		logic                       start_req;
		logic                       di_start_req;
		logic                       stop_req;
		logic                       hold;
		logic [31:0]                rd;

		cfg          = '0;
		mf           = s_q.pin_sync[2:0];
		mf_old       = s_q.pin_prev[2:0];
		di_start     = 1'b0;
		di_start_old = 1'b0;
		di_stop      = 1'b0;
		force_loc    = 1'b0;
		stop_dom     = 1'b0;
		emerg_lvl    = 1'b0;
		emerg_edge   = 1'b0;
		start_req    = 1'b0;
		di_start_req = 1'b0;
		stop_req     = 1'b0;
		hold         = 1'b0;
		rd           = '0;
		s_d          = s_q;

		// Two-stage synchroniser for the pins; only stage two is looked at.
		// Edge detectors compare stage two with its older copy, so a metastable
		// first stage can never reach a decision.
		s_d.pin_meta = {local_stop_input, local_forward_start_input, multifunction_inputs};
		s_d.pin_sync = s_q.pin_meta;
		s_d.pin_prev = s_q.pin_sync;
		s_d.cmd_r    = cmd;
		s_d.cmd_prev = s_q.cmd_r;

		// Override derived from whichever input carries that function.
		force_loc = csm_mf_any(s_q.mf_cfg, mf, csm_pkg::CSM_MF_FORCE);

		// Priority chain: fault, then override, then remote request.
		// Exactly one code is ever written, so the mode is always one-hot.
		if (s_q.cmd_r.bus_fault) begin
			s_d.mode = csm_pkg::CSM_MODE_LOCAL1;
		end else if (force_loc) begin
			s_d.mode = csm_pkg::CSM_MODE_LOCAL2;
		end else if (s_q.cmd_r.cyc_byte0[csm_pkg::REMOTE_BIT]) begin
			s_d.mode = csm_pkg::CSM_MODE_REMOTE;
		end else begin
			s_d.mode = csm_pkg::CSM_MODE_LOCAL1;
		end

		// Settings of the mode that is active now.
		unique case (s_q.mode)
			csm_pkg::CSM_MODE_REMOTE: begin
				cfg = s_q.cfg_rem;
			end
			csm_pkg::CSM_MODE_LOCAL1: begin
				cfg = s_q.cfg_l1;
			end
			csm_pkg::CSM_MODE_LOCAL2: begin
				cfg = s_q.cfg_l2;
			end
		endcase
		hold = cfg[csm_pkg::F_HOLD];

		// Local push buttons after their polarity flips.
		di_start     = s_q.pin_sync[3] ^ cfg[csm_pkg::F_START_FLIP];
		di_start_old = s_q.pin_prev[3] ^ cfg[csm_pkg::F_START_FLIP];
		di_stop      = s_q.pin_sync[4] ^ cfg[csm_pkg::F_STOP_FLIP];

		// Stop inputs dominate over every start source.
		stop_dom = csm_mf_any(s_q.mf_cfg, mf, csm_pkg::CSM_MF_STOP);

		// Test position switches to simulation while active.
		s_d.sim = csm_mf_any(s_q.mf_cfg, mf, csm_pkg::CSM_MF_TEST);

		// Starts react to a change to the active level, so a source may drop
		// its start again once accepted without stopping the motor.
		if (csm_rise(s_q.cmd_r.cyc_start, s_q.cmd_prev.cyc_start) &&
			cfg[csm_pkg::F_START_CYC]) begin
			start_req = 1'b1;
		end
		if (csm_rise(s_q.cmd_r.acyc_start, s_q.cmd_prev.acyc_start) &&
			cfg[csm_pkg::F_START_ACYC]) begin
			start_req = 1'b1;
		end
		if (csm_rise(s_q.cmd_r.pan_start, s_q.cmd_prev.pan_start) &&
			cfg[csm_pkg::F_START_PAN]) begin
			start_req = 1'b1;
		end
		if (csm_rise(di_start, di_start_old) && cfg[csm_pkg::F_START_DI]) begin
			di_start_req = 1'b1;
		end

		// Stops act as levels; a held stop keeps the motor off.
		stop_req = (s_q.cmd_r.cyc_stop && cfg[csm_pkg::F_STOP_CYC]) ||
			(s_q.cmd_r.acyc_stop && cfg[csm_pkg::F_STOP_ACYC]) ||
			(s_q.cmd_r.pan_stop && cfg[csm_pkg::F_STOP_PAN]) ||
			(di_stop && cfg[csm_pkg::F_STOP_DI]) || stop_dom;

		// Run latch: stop wins over start in the same cycle.
		// A bus or panel start during a hold-to-run start clears the hold flag,
		// so the motor then keeps running after the pin is released.
		s_d.accepted = 1'b0;
		if (stop_req) begin
			s_d.run      = 1'b0;
			s_d.hold_run = 1'b0;
		end else if (s_q.hold_run && !(di_start && hold)) begin
			s_d.run      = 1'b0;
			s_d.hold_run = 1'b0;
		end else if (start_req || di_start_req) begin
			s_d.run      = 1'b1;
			s_d.accepted = 1'b1;
			s_d.hold_run = di_start_req && hold && !start_req;
		end

		// Emergency start: both the input and the bus command need the enable.
		emerg_lvl  = csm_mf_any(s_q.mf_cfg, mf, csm_pkg::CSM_MF_EMERG);
		emerg_edge = emerg_lvl && !csm_mf_any(s_q.mf_cfg, mf_old, csm_pkg::CSM_MF_EMERG);
		s_d.th_reset = s_q.emerg_en && (emerg_edge ||
			csm_rise(s_q.cmd_r.thermal_reset_command,
				s_q.cmd_prev.thermal_reset_command));
		s_d.f_ign = s_q.emerg_en &&
			(emerg_lvl ||
			s_q.cmd_r.thermal_reset_command);

		// The mask follows the levels, so faults stay hidden for as long as either
		// emergency source is held, not only in the cycle of its edge.
		// Fault inputs raise their own flag unless masked.
		for (int i = 0; i < 3; i++) begin
			s_d.fault[i] = mf[i] && !s_d.f_ign &&
				(s_q.mf_cfg[i*3 +: 3] == csm_pkg::CSM_MF_FAULT);
		end

		// Readback value of the addressed word; unmapped words read zero.
		unique case (avs_req.address)
			csm_pkg::OFS_CTRL: begin
				rd = {31'h0000_0000, s_q.emerg_en};
			end
			csm_pkg::OFS_REMOTE: begin
				rd = {21'h00_0000, s_q.cfg_rem};
			end
			csm_pkg::OFS_LOCAL1: begin
				rd = {21'h00_0000, s_q.cfg_l1};
			end
			csm_pkg::OFS_LOCAL2: begin
				rd = {21'h00_0000, s_q.cfg_l2};
			end
			csm_pkg::OFS_MFCFG: begin
				rd = {23'h00_0000, s_q.mf_cfg};
			end
			csm_pkg::OFS_STATUS: begin
				// Pins, mode, run state and fault flags in the low fifteen bits.
				rd = {17'h0_0000, s_q.fault, s_q.f_ign, s_q.sim, s_q.hold_run,
					s_q.run, s_q.mode, s_q.pin_sync};
			end
			default: begin
				rd = 32'h0000_0000;
			end
		endcase

		// Bus slave: a request is answered one cycle after it is seen; a write
		// lands on the edge where the master samples waitrequest low.
		if (!s_q.waitreq) begin
			s_d.waitreq = 1'b1;
			if (avs_req.write) begin
				unique case (avs_req.address)
					csm_pkg::OFS_CTRL: begin
						s_d.emerg_en = avs_req.writedata[0];
					end
					csm_pkg::OFS_REMOTE: begin
						s_d.cfg_rem = avs_req.writedata[csm_pkg::MODE_W-1:0];
					end
					csm_pkg::OFS_LOCAL1: begin
						s_d.cfg_l1 = avs_req.writedata[csm_pkg::MODE_W-1:0];
					end
					csm_pkg::OFS_LOCAL2: begin
						s_d.cfg_l2 = avs_req.writedata[csm_pkg::MODE_W-1:0];
					end
					csm_pkg::OFS_MFCFG: begin
						s_d.mf_cfg = avs_req.writedata[8:0];
					end
					// Unmapped words and the read-only status word are answered
					// like any other, but nothing changes.
					default: begin
						s_d.waitreq = 1'b1;
					end
				endcase
			end
		end else if (avs_req.read || avs_req.write) begin
			s_d.waitreq = 1'b0;
			s_d.rdata   = rd;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Synchronous reset; the emergency enable comes up off.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q          <= '0;
			s_q.emerg_en <= csm_pkg::RST_EMERG;
			s_q.cfg_rem  <= csm_pkg::RST_REMOTE;
			s_q.cfg_l1   <= csm_pkg::RST_LOCAL;
			s_q.cfg_l2   <= csm_pkg::RST_LOCAL;
			s_q.mf_cfg   <= csm_pkg::RST_MFCFG;
			s_q.mode     <= csm_pkg::CSM_MODE_LOCAL1;
			s_q.waitreq  <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all straight from the state register
	// ------------------------------------------------------------------
	// No logic sits after the register, so consumers see clean levels and
	// pulses that start and end exactly on a clock edge.
	assign avs_readdata    = s_q.rdata;
	assign avs_waitrequest = s_q.waitreq;
	assign mode            = s_q.mode;
	assign motor_run       = s_q.run;
	assign start_accepted  = s_q.accepted;
	assign simulation      = s_q.sim;
	assign thermal_reset   = s_q.th_reset;
	assign fault_ignore    = s_q.f_ign;
	assign input_fault     = s_q.fault;

endmodule
